//--- rtl/hms_halt_sequencer.sv
// Purpose: sequencer for the timed halt and full halt low-power states
// Assumes: cpu core presents executed opcodes; inputs synchronous to clk
// Notes: clock enables are registered from the next state, so gating changes on the same edge as the state
//
// Overview of operation
// - halt with time-base interrupt enable set enters timed halt.
// - halt with time-base interrupt enable clear enters full halt.
// - timed halt ends on time-base interrupt, wake-capable interrupt or reset.
// - interrupt wake from timed halt skips the stabilisation wait.
// - reset wake from timed halt waits for stabilisation first.
// - halt entry forces mask bits to 10b; pending interrupt wakes at once.
// - timed halt runs only oscillator and time-base counter.
// - timed halt entry with watchdog active gives no reset.
// - full halt ends only on wake-capable interrupt or reset, not time-base.
// - any full halt wake restarts oscillator and waits 4096 cycles.
// - full halt stops the oscillator and all internal processing.
// - watchdog-halt option decides if halting with watchdog gives a reset.
// - service pushes condition code, loads priority, restores on pop.
// - opcode 8Eh is the halt instruction.
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`include "hms_defs.svh"

module hms_halt_sequencer
   import hms_pkg::*;
#(
   parameter int NIRQ = 14,
   parameter logic [13:0] WAKE_MASK = `HMS_WAKE_MASK,
   parameter int TB_IDX = `HMS_TB_IRQ_IDX,
   parameter int STAB_CYCLES = `HMS_STAB_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // cpu core
   input wire logic opcode_exec,
   input wire logic [7:0] opcode,
   input wire logic cc_pop,
   input wire logic [1:0] sw_priority,
   output logic [1:0] cc_mask,
   output logic cc_push,
   output logic irq_service,
   output logic [3:0] irq_vector,
   output logic reset_fetch,
   // wake sources and watchdog
   input wire logic [13:0] irq_pending,
   input wire logic reset_req,
   input wire logic watchdog_enabled,
   output logic watchdog_reset,
   // clock controls
   output logic cpu_clk_en,
   output logic periph_clk_en,
   output logic osc_run,
   output logic timebase_run
);

   // lowest source number wins, as in the interrupt priority order
   function automatic logic [3:0] prio_enc(input logic [13:0] req);
      logic [3:0] idx;
      idx = 4'h0;
      for (int i = NIRQ - 1; i >= 0; i--) begin
         if (req[i]) begin
            idx = 4'(i);
         end
      end
      return idx;
   endfunction

   // halt opcode decode
   function automatic logic is_halt(input logic [7:0] op);
      return op == `HMS_HALT_OPCODE;
   endfunction

   hms_state_t state_reg;
   hms_state_t state_next;
   logic [1:0] ctrl_reg;
   logic [1:0] ctrl_next;
   logic [3:0] wake_vec_reg;
   logic [3:0] wake_vec_next;
   logic wake_rst_reg;
   logic wake_rst_next;
   logic wdg_seen_reg;
   logic wdg_seen_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic service_reg;
   logic service_next;
   logic [3:0] vector_reg;
   logic [3:0] vector_next;
   logic fetch_reg;
   logic fetch_next;
   logic wdg_reg;
   logic wdg_next;
   logic cpu_en_reg;
   logic periph_en_reg;
   logic osc_reg;
   logic tb_run_reg;

   logic tb_en;
   logic wdg_opt;
   logic [13:0] tb_bit;
   logic [13:0] ah_wake;
   logic [13:0] fh_wake;
   logic halt_exec;
   logic wdg_trip;
   logic any_pend;
   logic halt_enter;
   logic stab_start;
   logic stab_busy;
   logic stab_done;
   logic ctrl_hit;
   logic [7:0] status_word;
   logic [7:0] wake_word;
   logic [7:0] read_mux;

   // control bits and wake source selection
   assign tb_en = ctrl_reg[`HMS_CTRL_TB_EN_BIT];
   assign wdg_opt = ctrl_reg[`HMS_CTRL_WDG_OPT_BIT];
   assign tb_bit = 14'(1) << TB_IDX;
   assign ah_wake = irq_pending & (WAKE_MASK | tb_bit);
   assign fh_wake = irq_pending & WAKE_MASK & ~tb_bit;
   assign any_pend = |irq_pending;

   // halt decode; option 0 with watchdog on and no time base trips a reset
   assign halt_exec = opcode_exec & is_halt(opcode) & (state_reg == HMS_RUN) & ~reset_req;
   assign wdg_trip = halt_exec & watchdog_enabled & ~tb_en & ~wdg_opt;
   assign halt_enter = halt_exec & ~wdg_trip;

   // next state and one-cycle actions
   always_comb begin
      state_next = state_reg;
      wake_vec_next = wake_vec_reg;
      wake_rst_next = wake_rst_reg;
      service_next = 1'b0;
      vector_next = vector_reg;
      fetch_next = 1'b0;
      wdg_next = 1'b0;
      stab_start = 1'b0;
      case (state_reg)
         HMS_RUN: begin
            if (reset_req) begin
               fetch_next = 1'b1;
            end else if (wdg_trip) begin
               wdg_next = 1'b1;
            end else if (halt_enter && any_pend) begin
               service_next = 1'b1;
               vector_next = prio_enc(irq_pending);
            end else if (halt_enter) begin
               state_next = tb_en ? HMS_AHALT : HMS_FHALT;
            end
         end
         HMS_AHALT: begin
            if (reset_req) begin
               state_next = HMS_STAB;
               stab_start = 1'b1;
               wake_rst_next = 1'b1;
            end else if (|ah_wake) begin
               state_next = HMS_RUN;
               service_next = 1'b1;
               vector_next = prio_enc(ah_wake);
               wake_vec_next = prio_enc(ah_wake);
               wake_rst_next = 1'b0;
            end
         end
         HMS_FHALT: begin
            if (reset_req) begin
               state_next = HMS_STAB;
               stab_start = 1'b1;
               wake_rst_next = 1'b1;
            end else if (|fh_wake) begin
               state_next = HMS_STAB;
               stab_start = 1'b1;
               wake_vec_next = prio_enc(fh_wake);
               wake_rst_next = 1'b0;
            end
         end
         HMS_STAB: begin
            if (stab_done) begin
               state_next = HMS_RUN;
               service_next = ~wake_rst_reg;
               fetch_next = wake_rst_reg;
               vector_next = wake_vec_reg;
            end
         end
         default: begin
            state_next = HMS_RUN;
         end
      endcase
   end

   // sequencer flops
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= HMS_RUN;
         wake_vec_reg <= 4'h0;
         wake_rst_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         wake_vec_reg <= wake_vec_next;
         wake_rst_reg <= wake_rst_next;
      end
   end

   // action pulses to the core
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         service_reg <= 1'b0;
         vector_reg <= 4'h0;
         fetch_reg <= 1'b0;
         wdg_reg <= 1'b0;
      end else begin
         service_reg <= service_next;
         vector_reg <= vector_next;
         fetch_reg <= fetch_next;
         wdg_reg <= wdg_next;
      end
   end

   // clock controls follow the next state so they change with it
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cpu_en_reg <= 1'b1;
         periph_en_reg <= 1'b1;
         osc_reg <= 1'b1;
         tb_run_reg <= 1'b1;
      end else begin
         cpu_en_reg <= state_next == HMS_RUN;
         periph_en_reg <= state_next == HMS_RUN;
         osc_reg <= state_next != HMS_FHALT;
         tb_run_reg <= state_next != HMS_FHALT;
      end
   end

   // stabilisation wait counter
   hms_stab_counter #(
      .STAB_CYCLES(STAB_CYCLES)
   ) u_stab (
      .clk(clk),
      .rstn(rstn),
      .start(stab_start),
      .busy(stab_busy),
      .done(stab_done)
   );

   // condition code mask bits
   hms_cc_mask u_cc (
      .clk(clk),
      .rstn(rstn),
      .halt_enter(halt_enter),
      .service(service_next),
      .pop(cc_pop),
      .sw_priority(sw_priority),
      .cc_mask(cc_mask)
   );

   // register decode; watchdog-trip flag sets over a clear in the same cycle
   assign ctrl_hit = reg_wr & (reg_addr == `HMS_CTRL_ADDR);
   assign ctrl_next = ctrl_hit ? reg_wdata[1:0] : ctrl_reg;
   assign wdg_seen_next = wdg_next | (wdg_seen_reg & ~(reg_wr & (reg_addr == `HMS_WAKE_ADDR)
                          & reg_wdata[`HMS_WAKE_WDG_BIT]));

   // read words; unmapped addresses read zero
   assign status_word = {1'b0, stab_busy, cc_mask, state_reg};
   assign wake_word = {2'b00, wdg_seen_reg, wake_rst_reg, wake_vec_reg};
   assign read_mux = (reg_addr == `HMS_CTRL_ADDR) ? {6'h00, ctrl_reg} :
                     (reg_addr == `HMS_STATUS_ADDR) ? status_word :
                     (reg_addr == `HMS_WAKE_ADDR) ? wake_word : 8'h00;
   assign rdata_next = reg_rd ? read_mux : 8'h00;

   // register flops
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_reg <= `HMS_CTRL_RESET;
         wdg_seen_reg <= 1'b0;
         rdata_reg <= 8'h00;
      end else begin
         ctrl_reg <= ctrl_next;
         wdg_seen_reg <= wdg_seen_next;
         rdata_reg <= rdata_next;
      end
   end

   // outputs
   assign reg_rdata = rdata_reg;
   assign cc_push = service_reg;
   assign irq_service = service_reg;
   assign irq_vector = vector_reg;
   assign reset_fetch = fetch_reg;
   assign watchdog_reset = wdg_reg;
   assign cpu_clk_en = cpu_en_reg;
   assign periph_clk_en = periph_en_reg;
   assign osc_run = osc_reg;
   assign timebase_run = tb_run_reg;

endmodule // hms_halt_sequencer

//--- rtl/hms_defs.svh
// Purpose: constants for the halt mode sequencer
// Assumes: 8-bit register port, 4-bit word addresses
// Notes: every offset and field position, the control and mask reset values and the wait count live here
`ifndef HMS_DEFS_SVH
`define HMS_DEFS_SVH

// register addresses
`define HMS_CTRL_ADDR 4'h0
`define HMS_STATUS_ADDR 4'h1
`define HMS_WAKE_ADDR 4'h2

// control fields
`define HMS_CTRL_TB_EN_BIT 0
`define HMS_CTRL_WDG_OPT_BIT 1
`define HMS_CTRL_RESET 2'h0

// status fields: state one-hot in [3:0], mask bits [5:4], counter busy 6
`define HMS_STAT_STATE_LSB 0
`define HMS_STAT_CC_LSB 4
`define HMS_STAT_BUSY_BIT 6

// wake cause fields: vector [3:0], woken by reset 4, watchdog tripped 5
`define HMS_WAKE_VEC_LSB 0
`define HMS_WAKE_RST_BIT 4
`define HMS_WAKE_WDG_BIT 5

// instruction and mask values
`define HMS_HALT_OPCODE 8'h8E
`define HMS_CC_HALT_MASK 2'h2
`define HMS_CC_RESET 2'h3

// wake-capable sources and the time-base source number
`define HMS_WAKE_MASK 14'h002B
`define HMS_TB_IRQ_IDX 5

// oscillator stabilisation wait, in cpu cycles
`define HMS_STAB_CYCLES 4096

`endif

//--- rtl/hms_pkg.sv
// Purpose: shared types of the halt mode sequencer
// Assumes: hms_defs.svh holds the numbers
// Notes: states are one-hot
package hms_pkg;

   // sequencer states
   typedef enum logic [3:0] {
      HMS_RUN   = 4'b0001,
      HMS_AHALT = 4'b0010,
      HMS_FHALT = 4'b0100,
      HMS_STAB  = 4'b1000
   } hms_state_t;

endpackage

//--- rtl/hms_stab_counter.sv
// Purpose: oscillator stabilisation wait counter
// Assumes: start is a one-cycle pulse on the wake event
// Notes: done is a registered one-cycle pulse when the count is reached
`timescale 1ns/1ps
`include "hms_defs.svh"

module hms_stab_counter #(
   parameter int STAB_CYCLES = `HMS_STAB_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // control
   input wire logic start,
   // status
   output logic busy,
   output logic done
);

   localparam int CW = $clog2(STAB_CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(STAB_CYCLES - 1);

   logic [CW-1:0] count_reg;
   logic [CW-1:0] count_next;
   logic busy_reg;
   logic busy_next;
   logic done_reg;
   logic done_next;
   logic at_last;

   // count clears on start and steps every cpu cycle while busy
   assign at_last = busy_reg & (count_reg == LAST);
   assign count_next = start ? '0 : (busy_reg ? count_reg + CW'(1) : count_reg);
   assign busy_next = start | (busy_reg & ~at_last);
   assign done_next = at_last & ~start;

   // state flops
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         count_reg <= '0;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         count_reg <= count_next;
         busy_reg <= busy_next;
         done_reg <= done_next;
      end
   end

   assign busy = busy_reg;
   assign done = done_reg;

endmodule // hms_stab_counter

//--- rtl/hms_cc_mask.sv
// Purpose: interrupt-mask bits of the condition code register
// Assumes: one saved copy stands for the pushed stack entry
// Notes: nesting deeper than one level is kept by the core's own stack
`timescale 1ns/1ps
`include "hms_defs.svh"

module hms_cc_mask (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // events
   input wire logic halt_enter,
   input wire logic service,
   input wire logic pop,
   input wire logic [1:0] sw_priority,
   // mask bits
   output logic [1:0] cc_mask
);

   logic [1:0] mask_reg;
   logic [1:0] mask_next;
   logic [1:0] saved_reg;
   logic [1:0] saved_next;

   // service loads priority even on a halt that wakes at once; halt entry forces 10b; pop restores
   assign mask_next = service ? sw_priority :
                      halt_enter ? `HMS_CC_HALT_MASK :
                      pop ? saved_reg : mask_reg;
   // a wake at halt entry pushes the forced 10b, not the old run mask
   assign saved_next = service ? (halt_enter ? `HMS_CC_HALT_MASK : mask_reg) : saved_reg;

   // mask flops
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mask_reg <= `HMS_CC_RESET;
         saved_reg <= `HMS_CC_RESET;
      end else begin
         mask_reg <= mask_next;
         saved_reg <= saved_next;
      end
   end

   assign cc_mask = mask_reg;

endmodule // hms_cc_mask

//--- tb/hms_asserts.sv
// Purpose: port checks for the halt mode sequencer
// Assumes: one clock domain, bound to the sequencer top
// Notes: stab_q and stab_cnt track the oscillator wait from outside
`timescale 1ns/1ps
module hms_asserts #(
   parameter int STAB_CYCLES = 8,
   parameter logic [13:0] WAKE_MASK = 14'h002B,
   parameter int TB_IDX = 5
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // cpu core
   input wire logic opcode_exec,
   input wire logic [7:0] opcode,
   input wire logic [1:0] sw_priority,
   input wire logic [1:0] cc_mask,
   input wire logic cc_push,
   input wire logic irq_service,
   input wire logic reset_fetch,
   // wake sources
   input wire logic [13:0] irq_pending,
   input wire logic reset_req,
   input wire logic watchdog_reset,
   // clock controls
   input wire logic cpu_clk_en,
   input wire logic periph_clk_en,
   input wire logic osc_run,
   input wire logic timebase_run
);
   logic stab_q;
   logic [15:0] stab_cnt;
   // cpu_clk_en high means the sequencer is running
   wire halt_op = opcode_exec && opcode == 8'h8E && cpu_clk_en && !reset_req;
   wire nontb_wake = (irq_pending & WAKE_MASK & ~(14'h1 << TB_IDX)) != 14'h0;
   // wait tracker: a reset in halt or a full halt wake starts it
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stab_q <= 1'b0;
         stab_cnt <= 16'h0;
      end else begin
         stab_q <= !cpu_clk_en && (stab_q || reset_req || (!osc_run && nontb_wake));
         stab_cnt <= stab_q ? stab_cnt + 16'h1 : 16'h0;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   a_halt_gates: assert property (halt_op && irq_pending == 14'h0 |=> !cpu_clk_en || watchdog_reset)
      else $error("halt left the cpu clock running");
   a_halt_mask: assert property (halt_op && irq_pending == 14'h0 |=> watchdog_reset || cc_mask == 2'h2)
      else $error("halt entry did not force mask 10b");
   a_pend_wake: assert property (halt_op && irq_pending != 14'h0 |=> irq_service && cc_push && cpu_clk_en)
      else $error("pending interrupt did not wake at once");
   a_timed_clocks: assert property (!cpu_clk_en && osc_run |-> timebase_run && !periph_clk_en)
      else $error("timed halt clocks wrong");
   a_full_stop: assert property (!osc_run |-> !timebase_run && !cpu_clk_en && !periph_clk_en)
      else $error("full halt left a clock running");
   a_timed_wake: assert property (!cpu_clk_en && osc_run && !stab_q && !reset_req
      && (irq_pending & WAKE_MASK) != 14'h0 |=> irq_service && cpu_clk_en)
      else $error("timed halt wake not immediate");
   a_full_hold: assert property (!osc_run && !reset_req && !nontb_wake |=> !osc_run)
      else $error("full halt left without a wake source");
   a_stab_wait: assert property (stab_q && (irq_service || reset_fetch)
      |-> stab_cnt >= STAB_CYCLES + 1 && stab_cnt <= STAB_CYCLES + 3)
      else $error("oscillator wait length wrong");
   a_stab_bound: assert property (stab_q |-> stab_cnt <= STAB_CYCLES + 3)
      else $error("oscillator wait never ended");
   a_wdg_cause: assert property (watchdog_reset |-> $past(halt_op) && cpu_clk_en)
      else $error("watchdog reset without halt");
   a_service_prio: assert property (irq_service |-> cc_push && cc_mask == $past(sw_priority))
      else $error("service did not push and load priority");
   a_other_op: assert property (opcode_exec && opcode != 8'h8E && cpu_clk_en && !reset_req
      && irq_pending == 14'h0 |=> cpu_clk_en)
      else $error("non-halt opcode stopped the cpu");
   c_timed_wake: cover property (!cpu_clk_en && osc_run && !stab_q ##1 irq_service);
   c_stab_wake: cover property (stab_q && irq_service);
   c_stab_reset: cover property (stab_q && reset_fetch);
   c_wdg: cover property (watchdog_reset);
endmodule // hms_asserts

//--- tb/hms_core_model.sv
// Purpose: cpu core model facing the sequencer
// Assumes: op_req is a one-cycle request from the bench
// Notes: idle opcode bus toggles so a stale halt never looks valid
`timescale 1ns/1ps
module hms_core_model #(
   parameter logic [1:0] SWP = 2'h1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // bench requests
   input wire logic op_req,
   input wire logic [7:0] op_val,
   // sequencer side
   input wire logic irq_service,
   output logic opcode_exec,
   output logic [7:0] opcode,
   output logic cc_pop,
   output logic [1:0] sw_priority
);
   logic [2:0] pop_dly;
   // routine priority, popped a few cycles after each service
   assign sw_priority = SWP;
   assign cc_pop = pop_dly == 3'h1;
   // one opcode per request
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         opcode_exec <= 1'b0;
         opcode <= 8'h00;
         pop_dly <= 3'h0;
      end else begin
         opcode_exec <= op_req;
         opcode <= op_req ? op_val : ~opcode;
         pop_dly <= irq_service ? 3'h3 : (pop_dly != 3'h0 ? pop_dly - 3'h1 : 3'h0);
      end
   end
endmodule // hms_core_model

//--- tb/tb_hms_halt_sequencer.sv
// Purpose: self-checking bench for the halt mode sequencer
// Assumes: oscillator wait cut to SC cycles
// Notes: the bench clears irq flags as a vector fetch would
`timescale 1ns/1ps
module tb_hms_halt_sequencer;
   localparam int SC = 8;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic op_req = 1'b0;
   logic [7:0] op_val = 8'h00;
   logic [13:0] irq_pending = 14'h0;
   logic reset_req = 1'b0;
   logic watchdog_enabled = 1'b0;
   logic [7:0] reg_rdata, opcode, v;
   logic opcode_exec, cc_pop, cc_push, irq_service, reset_fetch, watchdog_reset;
   logic cpu_clk_en, periph_clk_en, osc_run, timebase_run;
   logic [1:0] sw_priority, cc_mask;
   logic [3:0] irq_vector;
   int miscompares = 0;
   int check_count = 0;
   int n;
   hms_halt_sequencer #(.STAB_CYCLES(SC)) hms_halt_sequencer_inst (.*);
   hms_core_model hms_core_model_inst (.*);
   // clock controls packed for one compare
   function automatic logic [7:0] clkv();
      return {4'h0, cpu_clk_en, periph_clk_en, osc_run, timebase_run};
   endfunction
   task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // data stands only in the cycle after the strobe
   task rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   task rdchk(input logic [3:0] a, input logic [7:0] exp, input string nm);
      logic [7:0] d;
      rd(a, d);
      chk(nm, exp, d);
   endtask
   // opcode through the core model; returns once its effect has landed
   task op(input logic [7:0] o, input logic [13:0] pend);
      @(posedge clk);
      op_req <= 1'b1;
      op_val <= o;
      irq_pending <= pend;
      @(posedge clk);
      op_req <= 1'b0;
      tick(1);
   endtask
   // raise wake sources, count edges until service or reset fetch
   task wake(input logic [13:0] irq, input logic rst);
      @(posedge clk);
      irq_pending <= irq;
      reset_req <= rst;
      n = 0;
      do begin
         @(posedge clk);
         reset_req <= 1'b0;
         #1;
         n++;
      end while (irq_service !== 1'b1 && reset_fetch !== 1'b1 && n < 60);
   endtask
   task final_report;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // 10 MHz clock
   initial begin
      forever #50 clk = ~clk;
   end
   // hang guard, far beyond the hundred or so cycles used
   initial begin
      #1000000;
      miscompares++;
      final_report;
   end
   // test sequence
   initial begin
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      tick(1);
      chk("clk_rst", 8'h0F, clkv());
      rdchk(4'h1, 8'h31, "status_rst");
      rdchk(4'hF, 8'h00, "unmapped");
      wr(4'h0, 8'h01);
      rdchk(4'h0, 8'h01, "ctrl");
      op(8'h8E, 14'h0);
      chk("clk_ah", 8'h03, clkv());
      rdchk(4'h1, 8'h22, "status_ah");
      wake(14'h0020, 1'b0);
      chk("ah_wake_n", 8'h01, n[7:0]);
      chk("vec_tb", 8'h05, {4'h0, irq_vector});
      chk("prio", 8'h01, {6'h0, cc_mask});
      tick(4);
      chk("pop", 8'h02, {6'h0, cc_mask});
      wr(4'h0, 8'h00);
      op(8'h8E, 14'h0);
      chk("clk_fh", 8'h00, clkv());
      @(posedge clk);
      irq_pending <= 14'h0020;
      tick(6);
      rdchk(4'h1, 8'h24, "status_fh");
      wake(14'h0021, 1'b0);
      chk("fh_wait", 8'h01, {7'h0, n >= SC + 2 && n <= SC + 4});
      chk("vec_fh", 8'h00, {4'h0, irq_vector});
      wr(4'h0, 8'h01);
      op(8'h8E, 14'h0);
      wake(14'h0, 1'b1);
      chk("rst_wait", 8'h01, {7'h0, reset_fetch === 1'b1 && n >= SC + 2 && n <= SC + 4});
      rd(4'h2, v);
      chk("wake_rst", 8'h10, v & 8'h10);
      op(8'h8E, 14'h0010);
      chk("pend", 8'h14, {3'h0, irq_service, irq_vector});
      chk("pend_mask", 8'h01, {6'h0, cc_mask});
      wr(4'h0, 8'h00);
      watchdog_enabled <= 1'b1;
      op(8'h8E, 14'h0);
      chk("wdg", 8'h03, {6'h0, watchdog_reset, cpu_clk_en});
      rd(4'h2, v);
      chk("wdg_flag", 8'h20, v & 8'h20);
      wr(4'h2, 8'h20);
      rd(4'h2, v);
      chk("wdg_clr", 8'h00, v & 8'h20);
      wr(4'h0, 8'h01);
      op(8'h8E, 14'h0);
      chk("wdg_ah", 8'h00, {6'h0, watchdog_reset, cpu_clk_en});
      wake(14'h0002, 1'b0);
      chk("vec_ei1", 8'h01, {4'h0, irq_vector});
      wr(4'h0, 8'h02);
      op(8'h8E, 14'h0);
      chk("wdg_opt", 8'h00, {6'h0, watchdog_reset, cpu_clk_en});
      rdchk(4'h1, 8'h24, "status_opt");
      wake(14'h0008, 1'b0);
      chk("vec_spi", 8'h03, {4'h0, irq_vector});
      op(8'h8D, 14'h0);
      chk("not_halt", 8'h01, {7'h0, cpu_clk_en});
      wake(14'h0, 1'b1);
      chk("run_rst", 8'h11, {3'h0, reset_fetch, n[3:0]});
      final_report;
   end
endmodule // tb_hms_halt_sequencer

bind hms_halt_sequencer hms_asserts #(.STAB_CYCLES(STAB_CYCLES), .WAKE_MASK(WAKE_MASK), .TB_IDX(TB_IDX))
   hms_asserts_inst (.*);
